// file: src/plc_flags_params.svh
/*
   Named constants for the line status change flag block: register
   indices, reset values, field positions and flag bit positions.
   Assumes it is included by the package and the design modules only.
*/
`ifndef PLC_FLAGS_PARAMS_SVH
`define PLC_FLAGS_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_W            6
`define IDX_CHG_FLAGS    6'h08
`define IDX_REG_FLAGS    6'h09
`define IDX_CHN_FLAGS    6'h0a
`define IDX_CHG_EN       6'h10
`define IDX_REG_EN       6'h11
`define IDX_CHN_EN       6'h12
`define IDX_CHG_CLR      6'h13
`define IDX_REG_CLR      6'h14
`define IDX_CHN_CLR      6'h15
`define IDX_COMM_CODE    6'h16
`define IDX_LEVELS       6'h17
`define IDX_PENDING      6'h18

// Reset values
`define FLAGS_RESET      8'h00
`define EN_RESET         8'h00
`define CODE_RESET       8'h00
`define LEVELS_RESET     24'h000000
`define RD_RESET         32'h00000000

// Field widths
`define CHG_MODE_W       3
`define TEMP_W           3
`define LEVEL_W          24

// Positions inside the watched level vector
`define LV_SUM_LIMIT     0
`define LV_SUM_CURRENT   1
`define LV_THERMAL       2
`define LV_CC_TIMEOUT    3
`define LV_MODE_LO       4
`define LV_MODE_HI       6
`define LV_SYS_MIN       7
`define LV_RESTART       8
`define LV_TEMP_LO       9
`define LV_TEMP_HI       11
`define LV_TEMP_ADJUST   12
`define LV_CHG_REVERSE   13
`define LV_VOLT_REG      14
`define LV_STEP_CHARGE   15
`define LV_CHG_DROPOUT   16
`define LV_SYS_DROPOUT   17
`define LV_LINE_GOOD     18
`define LV_SYS_REVERSE   19
`define LV_CONNECTED     20
`define LV_WAITING       21
`define LV_IDLE          22
`define LV_SHORT_XFER    23

// Charger event flag bits
`define B_SUM_LIMIT      7
`define B_SUM_CURRENT    6
`define B_THERMAL        5
`define B_CC_TIMEOUT     4
`define B_MODE           3
`define B_SYS_MIN        2
`define B_RESTART        1
`define B_BATT_TEMP      0

// Regulation event flag bits
`define B_TEMP_ADJUST    7
`define B_CHG_REVERSE    6
`define B_VOLT_REG       5
`define B_STEP_CHARGE    4
`define B_CHG_DROPOUT    3
`define B_SYS_DROPOUT    2
`define B_LINE_GOOD      1
`define B_SYS_REVERSE    0

// Line channel event flag bits
`define B_CONNECTED      7
`define B_WAITING        6
`define B_IDLE           5
`define B_XFER_RISE      4
`define B_XFER_FALL      3
`define B_NEW_DATA       2
`define B_CMD_DONE       1
`define B_CMD_ERROR      0

`endif

// file: src/plc_flags_pkg.sv
/*
   Types shared by the change flag block and its change detector.
   Assumes the params header is on the include path.
*/
`include "plc_flags_params.svh"

package plc_flags_pkg;

   typedef logic [7:0]              byte_t;
   typedef logic [`LEVEL_W-1:0]     level_t;

   // Change detector state
   typedef struct packed {
      level_t prev;
      logic   primed;
   } change_state_t;

   // Flag block state
   typedef struct packed {
      logic        ack;
      logic [31:0] rdData;
      byte_t       chgFlags;
      byte_t       regFlags;
      byte_t       chnFlags;
      byte_t       chgEn;
      byte_t       regEn;
      byte_t       chnEn;
      byte_t       code;
      logic        irq;
   } flags_state_t;

endpackage : plc_flags_pkg

// file: src/power_line_status_change_flags.sv
/*
   Three sticky event flag registers for the line slave with charger,
   an enable and a clear register per flag register, a latched
   communication status code and one level interrupt, all behind a
   classic Wishbone slave with 32-bit data. Assumes every status input
   and event pulse comes from logic on core_clk; event pulses are one
   cycle wide.
*/
// Contract
// - sum limit active change sets charger bit 7
// - sum current change sets charger bit 6
// - thermal regulation change sets charger bit 5
// - constant-current timeout change sets charger bit 4
// - any charger mode change sets charger bit 3
// - sys minimum sets bit 2, restart bit 1
// - battery temperature change sets charger bit 0
// - adjust, reverse, voltage, step set bits 7..4
// - charger dropout change sets regulation bit 3
// - sys dropout bit 2, sys reverse bit 0
// - line voltage good change sets bit 1
// - connected, waiting, idle set channel bits 7..5
// - short transfer rise alone sets channel bit 4
// - short transfer fall alone sets channel bit 3
// - new received data sets channel bit 2
// - command completion sets channel bit 1
// - command error sets channel bit 0
// - status code valid with done or error
`include "plc_flags_params.svh"

module power_line_status_change_flags (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // Wishbone slave
   input  wire logic                 wbCyc,
   input  wire logic                 wbStb,
   input  wire logic                 wbWe,
   input  wire logic [7:0]           wbAdr,
   input  wire logic [3:0]           wbSel,
   input  wire logic [31:0]          wbDatIn,
   output logic      [31:0]          wbDatOut,
   output logic                      wbAck,
   output logic                      irq,
   // Charger status levels
   input  wire logic                 sumLimitActive,
   input  wire logic                 sumCurrentState,
   input  wire logic                 chargerThermalState,
   input  wire logic                 ccPhaseTimeout,
   input  wire logic [2:0]           chargerMode,
   input  wire logic                 sysMinRegulating,
   input  wire logic                 chargerRestartState,
   input  wire logic [2:0]           batteryTempState,
   // Regulation status levels
   input  wire logic                 tempAdjustState,
   input  wire logic                 chargerReverseState,
   input  wire logic                 voltageRegMode,
   input  wire logic                 stepChargeState,
   input  wire logic                 chargerDropoutState,
   input  wire logic                 sysDropoutState,
   input  wire logic                 lineVoltageGood,
   input  wire logic                 sysReverseState,
   // Line channel status and events
   input  wire logic                 channelConnected,
   input  wire logic                 channelWaiting,
   input  wire logic                 channelIdle,
   input  wire logic                 shortTransfer,
   input  wire logic                 newDataPulse,
   input  wire logic                 cmdDonePulse,
   input  wire logic                 cmdErrorPulse,
   input  wire plc_flags_pkg::byte_t commStatusCode
);
   import plc_flags_pkg::*;

   localparam flags_state_t STATE_RESET = '{
      ack:      1'b0,
      rdData:   `RD_RESET,
      chgFlags: `FLAGS_RESET,
      regFlags: `FLAGS_RESET,
      chnFlags: `FLAGS_RESET,
      chgEn:    `EN_RESET,
      regEn:    `EN_RESET,
      chnEn:    `EN_RESET,
      code:     `CODE_RESET,
      irq:      1'b0
   };

   flags_state_t            s_reg;
   flags_state_t            s_next;
   level_t                  levels;
   level_t                  changed;
   level_t                  rose;
   level_t                  fell;
   byte_t                   chgSet;
   byte_t                   regSet;
   byte_t                   chnSet;
   byte_t                   chgClr;
   byte_t                   regClr;
   byte_t                   chnClr;
   logic                    access;
   logic                    wrAccess;
   logic [`IDX_W-1:0]       regIdx;
   logic [31:0]             rdWord;

   // Write-one-to-clear mask from either the flag register or its clear register
   function automatic byte_t clearMask(input logic              wr,
                                       input logic [`IDX_W-1:0] idx,
                                       input logic [`IDX_W-1:0] flagIdx,
                                       input logic [`IDX_W-1:0] clrIdx,
                                       input byte_t             data);
      byte_t m;
      m = `FLAGS_RESET;
      if (wr && ((idx == flagIdx) || (idx == clrIdx))) begin
         m = data;
      end
      return m;
   endfunction : clearMask

   // Watched levels packed in detector order, highest position first
   assign levels = {shortTransfer, channelIdle, channelWaiting, channelConnected,
                    sysReverseState, lineVoltageGood, sysDropoutState,
                    chargerDropoutState, stepChargeState, voltageRegMode,
                    chargerReverseState, tempAdjustState, batteryTempState,
                    chargerRestartState, sysMinRegulating, chargerMode,
                    ccPhaseTimeout, chargerThermalState, sumCurrentState,
                    sumLimitActive};

   // Change against the previous clock for every watched level
   status_change_detect u_detect (
      .core_clk (core_clk),
      .rst      (rst),
      .levels   (levels),
      .changed  (changed),
      .rose     (rose),
      .fell     (fell)
   );

   // Charger event sources
   always_comb begin
      chgSet                = `FLAGS_RESET;
      chgSet[`B_SUM_LIMIT]  = changed[`LV_SUM_LIMIT];
      chgSet[`B_SUM_CURRENT] = changed[`LV_SUM_CURRENT];
      chgSet[`B_THERMAL]    = changed[`LV_THERMAL];
      chgSet[`B_CC_TIMEOUT] = changed[`LV_CC_TIMEOUT];
      chgSet[`B_MODE]       = |changed[`LV_MODE_HI:`LV_MODE_LO];
      chgSet[`B_SYS_MIN]    = changed[`LV_SYS_MIN];
      chgSet[`B_RESTART]    = changed[`LV_RESTART];
      chgSet[`B_BATT_TEMP]  = |changed[`LV_TEMP_HI:`LV_TEMP_LO];
   end

   // Regulation event sources
   always_comb begin
      regSet                 = `FLAGS_RESET;
      regSet[`B_TEMP_ADJUST] = changed[`LV_TEMP_ADJUST];
      regSet[`B_CHG_REVERSE] = changed[`LV_CHG_REVERSE];
      regSet[`B_VOLT_REG]    = changed[`LV_VOLT_REG];
      regSet[`B_STEP_CHARGE] = changed[`LV_STEP_CHARGE];
      regSet[`B_CHG_DROPOUT] = changed[`LV_CHG_DROPOUT];
      regSet[`B_SYS_DROPOUT] = changed[`LV_SYS_DROPOUT];
      regSet[`B_LINE_GOOD]   = changed[`LV_LINE_GOOD];
      regSet[`B_SYS_REVERSE] = changed[`LV_SYS_REVERSE];
   end

   // Line channel event sources; short transfer edges are kept apart
   always_comb begin
      chnSet               = `FLAGS_RESET;
      chnSet[`B_CONNECTED] = changed[`LV_CONNECTED];
      chnSet[`B_WAITING]   = changed[`LV_WAITING];
      chnSet[`B_IDLE]      = changed[`LV_IDLE];
      chnSet[`B_XFER_RISE] = rose[`LV_SHORT_XFER];
      chnSet[`B_XFER_FALL] = fell[`LV_SHORT_XFER];
      chnSet[`B_NEW_DATA]  = newDataPulse;
      chnSet[`B_CMD_DONE]  = cmdDonePulse;
      chnSet[`B_CMD_ERROR] = cmdErrorPulse;
   end

   // Bus decode; ack is registered and masks the next cycle, so a held request sees an ack every other cycle
   assign access   = wbCyc & wbStb & ~s_reg.ack;
   assign wrAccess = access & wbWe & wbSel[0];
   assign regIdx   = wbAdr[`IDX_W+1:2];

   assign chgClr = clearMask(wrAccess, regIdx, `IDX_CHG_FLAGS, `IDX_CHG_CLR, wbDatIn[7:0]);
   assign regClr = clearMask(wrAccess, regIdx, `IDX_REG_FLAGS, `IDX_REG_CLR, wbDatIn[7:0]);
   assign chnClr = clearMask(wrAccess, regIdx, `IDX_CHN_FLAGS, `IDX_CHN_CLR, wbDatIn[7:0]);

   // Read mux; clear registers are write-only and unmapped space reads zero
   always_comb begin
      rdWord = `RD_RESET;
      case (regIdx)
         `IDX_CHG_FLAGS: begin
            rdWord[7:0] = s_reg.chgFlags;
         end
         `IDX_REG_FLAGS: begin
            rdWord[7:0] = s_reg.regFlags;
         end
         `IDX_CHN_FLAGS: begin
            rdWord[7:0] = s_reg.chnFlags;
         end
         `IDX_CHG_EN: begin
            rdWord[7:0] = s_reg.chgEn;
         end
         `IDX_REG_EN: begin
            rdWord[7:0] = s_reg.regEn;
         end
         `IDX_CHN_EN: begin
            rdWord[7:0] = s_reg.chnEn;
         end
         `IDX_COMM_CODE: begin
            rdWord[7:0] = s_reg.code;
         end
         `IDX_LEVELS: begin
            rdWord[`LEVEL_W-1:0] = levels;
         end
         `IDX_PENDING: begin
            rdWord[23:0] = {s_reg.chnFlags & s_reg.chnEn,
                            s_reg.regFlags & s_reg.regEn,
                            s_reg.chgFlags & s_reg.chgEn};
         end
         default: begin
            rdWord = `RD_RESET;
         end
      endcase
   end

   // Next state: set wins over a clear landing in the same cycle
   always_comb begin
      s_next     = s_reg;
      s_next.ack = access;
      if (access && !wbWe) begin
         s_next.rdData = rdWord;
      end
      s_next.chgFlags = (s_reg.chgFlags & ~chgClr) | chgSet;
      s_next.regFlags = (s_reg.regFlags & ~regClr) | regSet;
      s_next.chnFlags = (s_reg.chnFlags & ~chnClr) | chnSet;
      if (wrAccess && (regIdx == `IDX_CHG_EN)) begin
         s_next.chgEn = wbDatIn[7:0];
      end
      if (wrAccess && (regIdx == `IDX_REG_EN)) begin
         s_next.regEn = wbDatIn[7:0];
      end
      if (wrAccess && (regIdx == `IDX_CHN_EN)) begin
         s_next.chnEn = wbDatIn[7:0];
      end
      // Code is captured with the flag so it is valid when software looks
      if (cmdDonePulse || cmdErrorPulse) begin
         s_next.code = commStatusCode;
      end
      // Interrupt follows the flags in the same cycle they become visible
      s_next.irq = |{s_next.chgFlags & s_next.chgEn,
                     s_next.regFlags & s_next.regEn,
                     s_next.chnFlags & s_next.chnEn};
   end

   // State register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wbAck    = s_reg.ack;
   assign wbDatOut = s_reg.rdData;
   assign irq      = s_reg.irq;

endmodule : power_line_status_change_flags

// file: src/status_change_detect.sv
/*
   Compares each watched level with its value one clock earlier and
   reports any change, rise and fall. Assumes levels come from logic on
   core_clk, so no synchroniser is placed in front.
*/
`include "plc_flags_params.svh"

module status_change_detect (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire plc_flags_pkg::level_t levels,
   output      plc_flags_pkg::level_t changed,
   output      plc_flags_pkg::level_t rose,
   output      plc_flags_pkg::level_t fell
);
   import plc_flags_pkg::*;

   change_state_t s_reg;
   change_state_t s_next;

   // Remember the last level; first cycle after reset only primes, so
   // a level that is already high at release does not look like a change
   always_comb begin
      s_next        = s_reg;
      s_next.prev   = levels;
      s_next.primed = 1'b1;
      changed       = s_reg.primed ? (levels ^ s_reg.prev) : `LEVELS_RESET;
      rose          = s_reg.primed ? (levels & ~s_reg.prev) : `LEVELS_RESET;
      fell          = s_reg.primed ? (~levels & s_reg.prev) : `LEVELS_RESET;
   end

   // State register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg.prev   <= `LEVELS_RESET;
         s_reg.primed <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : status_change_detect

// file: tb/power_line_status_change_flags_props.sv
/*
   Checker for the change flag block: bus timing, read data, the
   channel flag register and the latched status code.
   Assumes binding to the top module, whose port names it reuses.
*/
module plc_flags_checker
   import plc_flags_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbWe,
   input wire logic [7:0]  wbAdr,
   input wire logic [3:0]  wbSel,
   input wire logic [31:0] wbDatIn,
   input wire logic [31:0] wbDatOut,
   input wire logic        wbAck,
   input wire logic        channelConnected,
   input wire logic        channelWaiting,
   input wire logic        channelIdle,
   input wire logic        shortTransfer,
   input wire logic        newDataPulse,
   input wire logic        cmdDonePulse,
   input wire logic        cmdErrorPulse,
   input wire byte_t       commStatusCode
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       taken;
   logic [3:0] lv;
   logic [3:0] lastLv;
   logic       primed;
   logic [7:0] chnModel;
   logic [7:0] clrMask;
   logic [7:0] setMask;
   byte_t      codeModel;

   // Reference for the channel flags; clear acts at the edge the request is taken
   assign taken   = wbCyc && wbStb && !wbAck;
   assign lv      = {channelConnected, channelWaiting, channelIdle, shortTransfer};
   assign clrMask = (taken && wbWe && wbSel[0] &&
                     (wbAdr[7:2] == 6'h0a || wbAdr[7:2] == 6'h15)) ? wbDatIn[7:0] : 8'h00;
   assign setMask = {primed ? {lv[3:1] ^ lastLv[3:1], lv[0] & ~lastLv[0],
                     ~lv[0] & lastLv[0]} : 5'h00, newDataPulse, cmdDonePulse, cmdErrorPulse};

   // First edge after reset only records levels
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lastLv    <= 4'h0;
         primed    <= 1'b0;
         chnModel  <= 8'h00;
         codeModel <= 8'h00;
      end else begin
         lastLv   <= lv;
         primed   <= 1'b1;
         chnModel <= (chnModel & ~clrMask) | setMask;
         if (cmdDonePulse || cmdErrorPulse) begin
            codeModel <= commStatusCode;
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   chk_ack_latency: assert property (taken |=> wbAck)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   chk_unmapped_zero: assert property (taken && !wbWe && wbAdr[7:2] > 6'h18 |=> wbDatOut == 32'h0)
      else $error("unmapped read not zero");
   chk_data_holds: assert property (!(taken && !wbWe) |=> $stable(wbDatOut))
      else $error("read data changed without read");
   chk_chn_status: assert property (
      taken && !wbWe && wbAdr[7:2] == 6'h0a |=> wbDatOut[31:3] == {24'h0, $past(chnModel[7:3])})
      else $error("channel status flags wrong");
   chk_chn_events: assert property (
      taken && !wbWe && wbAdr[7:2] == 6'h0a |=> wbDatOut[2:0] == $past(chnModel[2:0]))
      else $error("channel event flags wrong");
   chk_code_valid: assert property (
      taken && !wbWe && wbAdr[7:2] == 6'h16 |=> wbDatOut == {24'h0, $past(codeModel)})
      else $error("status code wrong");
endmodule : plc_flags_checker

bind power_line_status_change_flags plc_flags_checker plc_flags_checker_i (.*);

// file: tb/power_line_status_change_flags_tb.sv
/*
   Bench for the change flag block: toggles every watched level, pulses
   each event, exercises enables, clears and the interrupt over Wishbone.
   Assumes the design and checker are compiled before it.
*/
module power_line_status_change_flags_tb
   import plc_flags_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        core_clk, rst, wbCyc, wbStb, wbWe, wbAck, irq;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatIn, wbDatOut, rd;
   logic [23:0] f;
   byte_t       commStatusCode;
   level_t      lv;
   logic [2:0]  pv;
   int          errTotal, comparisons, cycles;
   int          flagPos [24] = '{7, 6, 5, 4, 3, 3, 3, 2, 1, 0, 0, 0,
                                 15, 14, 13, 12, 11, 10, 9, 8, 23, 22, 21, 20};
   logic [7:0]  rstAdr [7] = '{8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h48, 8'h58};

   power_line_status_change_flags power_line_status_change_flags_i (
      .*,
      .sumLimitActive(lv[0]), .sumCurrentState(lv[1]), .chargerThermalState(lv[2]),
      .ccPhaseTimeout(lv[3]), .chargerMode(lv[6:4]), .sysMinRegulating(lv[7]),
      .chargerRestartState(lv[8]), .batteryTempState(lv[11:9]), .tempAdjustState(lv[12]),
      .chargerReverseState(lv[13]), .voltageRegMode(lv[14]), .stepChargeState(lv[15]),
      .chargerDropoutState(lv[16]), .sysDropoutState(lv[17]), .lineVoltageGood(lv[18]),
      .sysReverseState(lv[19]), .channelConnected(lv[20]), .channelWaiting(lv[21]),
      .channelIdle(lv[22]), .shortTransfer(lv[23]), .newDataPulse(pv[2]),
      .cmdDonePulse(pv[1]), .cmdErrorPulse(pv[0])
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Hang guard, well above the roughly one thousand cycles the run needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errTotal++;
         printVerdict();
      end
   end

   task automatic printVerdict;
      if (errTotal == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : printVerdict

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Single classic cycle; ack and read data taken at one rising edge,
   // request released right after it, so the next call idles one cycle
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wbCyc   <= 1'b1;
      wbStb   <= 1'b1;
      wbWe    <= we;
      wbAdr   <= a;
      wbDatIn <= d;
      do @(posedge core_clk); while (wbAck !== 1'b1);
      rd = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : xfer

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask : rdChk

   task automatic readFlags;
      xfer(1'b0, 8'h28, 32'h0);
      f[23:16] = rd[7:0];
      xfer(1'b0, 8'h24, 32'h0);
      f[15:8] = rd[7:0];
      xfer(1'b0, 8'h20, 32'h0);
      f[7:0] = rd[7:0];
   endtask : readFlags

   task automatic clearAll;
      xfer(1'b1, 8'h20, 32'hff);
      xfer(1'b1, 8'h24, 32'hff);
      xfer(1'b1, 8'h28, 32'hff);
   endtask : clearAll

   task automatic irqChk(input logic exp, input string what);
      @(negedge core_clk);
      check(what, {31'h0, exp}, {31'h0, irq});
   endtask : irqChk

   initial begin
      rst = 1'b1;
      {wbCyc, wbStb, wbWe, wbAdr, wbDatIn, lv, pv, commStatusCode} = '0;
      wbSel = 4'hf;
      {errTotal, comparisons, cycles} = '0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      foreach (rstAdr[k]) rdChk(rstAdr[k], 32'h0, "reset value");
      // Each level raised then lowered; three cycles covers detect latency
      for (int i = 0; i < 24; i++) begin
         lv[i] <= 1'b1;
         repeat (3) @(posedge core_clk);
         readFlags();
         check("rise flags", 32'h1 << flagPos[i], {8'h0, f});
         clearAll();
         lv[i] <= 1'b0;
         repeat (3) @(posedge core_clk);
         readFlags();
         check("fall flags", (i == 23) ? 32'h80000 : 32'h1 << flagPos[i], {8'h0, f});
         clearAll();
      end
      // Events: code follows done and error only
      for (int k = 0; k < 3; k++) begin
         commStatusCode <= 8'h10 + 8'(k);
         pv[k] <= 1'b1;
         @(posedge core_clk);
         pv[k] <= 1'b0;
         commStatusCode <= 8'h00;
         repeat (2) @(posedge core_clk);
         rdChk(8'h28, 32'h1 << k, "event flags");
         rdChk(8'h58, (k == 2) ? 32'h11 : 32'h10 + k, "status code");
         xfer(1'b1, 8'h28, 32'hff);
      end
      // Interrupt: raise, mask, unmask, clear through clear register
      xfer(1'b1, 8'h40, 32'h80);
      lv[0] <= 1'b1;
      repeat (3) @(posedge core_clk);
      irqChk(1'b1, "irq raised");
      rdChk(8'h60, 32'h80, "pending");
      xfer(1'b1, 8'h40, 32'h00);
      irqChk(1'b0, "irq masked");
      xfer(1'b1, 8'h40, 32'h80);
      irqChk(1'b1, "irq sticky");
      xfer(1'b1, 8'h4c, 32'h80);
      irqChk(1'b0, "irq cleared");
      rdChk(8'h20, 32'h0, "flags cleared");
      // Clear registers of the other two flag bytes, after a real set
      lv[12] <= 1'b1;
      pv[2]  <= 1'b1;
      @(posedge core_clk);
      pv[2] <= 1'b0;
      repeat (2) @(posedge core_clk);
      readFlags();
      check("reg and chn set", 32'h48000, {8'h0, f});
      xfer(1'b1, 8'h50, 32'h80);
      xfer(1'b1, 8'h54, 32'h04);
      rdChk(8'h24, 32'h0, "reg flags cleared");
      rdChk(8'h28, 32'h0, "chn flags cleared");
      rdChk(8'h5c, 32'h1001, "live levels");
      // Write without lane 0 is ignored; unmapped reads zero
      wbSel <= 4'h0;
      xfer(1'b1, 8'h40, 32'h00);
      wbSel <= 4'hf;
      rdChk(8'h40, 32'h80, "enable readback");
      rdChk(8'hfc, 32'h0, "unmapped");
      printVerdict();
   end
endmodule : power_line_status_change_flags_tb
